// File: lfss_pkg.sv
// lfss_pkg: constants and carrier types for the lock, fuse and signature store
// assumes: included before all lfss design modules
package lfss_pkg;
  // lock byte layout, all bits read 1 when unprogrammed
  localparam int          LFSS_LOCK_LOW_BIT   = 0;
  localparam int          LFSS_LOCK_HIGH_BIT  = 1;
  localparam logic [7:0]  LFSS_LOCK_RESET     = 8'hFF;
  localparam logic [7:0]  LFSS_LOCK_UNUSED    = 8'hFC;
  // extended fuse byte
  localparam int          LFSS_SELF_PROG_BIT  = 0;
  localparam logic [7:0]  LFSS_EXT_DEFAULT    = 8'hFF;
  localparam logic [7:0]  LFSS_EXT_UNUSED     = 8'hFE;
  // high fuse byte
  localparam int          LFSS_RST_DIS_BIT    = 7;
  localparam int          LFSS_DEBUG_BIT      = 6;
  localparam int          LFSS_SERIAL_BIT     = 5;
  localparam int          LFSS_WDT_ON_BIT     = 4;
  localparam int          LFSS_PRESERVE_BIT   = 3;
  localparam logic [7:0]  LFSS_HIGH_DEFAULT   = 8'hDF;
  // low fuse byte: divide-by-eight on, clock out off, start-up 10, source 0010
  localparam logic [7:0]  LFSS_LOW_DEFAULT    = 8'h62;
  // firmware pointer values for fuse and lock reads
  localparam logic [15:0] LFSS_PTR_FUSE_LOW   = 16'h0000;
  localparam logic [15:0] LFSS_PTR_LOCK       = 16'h0001;
  localparam logic [15:0] LFSS_PTR_FUSE_EXT   = 16'h0002;
  localparam logic [15:0] LFSS_PTR_FUSE_HIGH  = 16'h0003;
  // signature table indices
  localparam logic [7:0]  LFSS_SIG_IDX0       = 8'h00;
  localparam logic [7:0]  LFSS_SIG_IDX_CAL    = 8'h01;
  localparam logic [7:0]  LFSS_SIG_IDX1       = 8'h02;
  localparam logic [7:0]  LFSS_SIG_IDX2       = 8'h04;
  localparam logic [7:0]  LFSS_SIG_RESERVED   = 8'hFF;
  // control register bits
  localparam int          LFSS_CTL_STORE_EN   = 0;
  localparam int          LFSS_CTL_READ_FUSE  = 3;
  localparam int          LFSS_CTL_READ_SIG   = 5;
  localparam logic [7:0]  LFSS_CTL_MASK       = 8'h29;
  // arm window of the read request, in cycles
  localparam logic [1:0]  LFSS_ARM_CYCLES     = 2'h3;

  typedef enum logic [1:0] {
    LFSS_TGT_LOCK,
    LFSS_TGT_EXT,
    LFSS_TGT_HIGH,
    LFSS_TGT_LOW
  } lfss_target_t;

  typedef enum logic [1:0] {
    LFSS_PORT_NONE,
    LFSS_PORT_SERIAL,
    LFSS_PORT_HV
  } lfss_port_t;

  // programmer request
  typedef struct packed {
    logic         write;
    logic         erase;
    lfss_target_t target;
    logic [7:0]   data;
  } lfss_prog_req_t;

  // decoded working settings
  typedef struct packed {
    logic self_prog_enable;
    logic debug_link_enable;
    logic watchdog_forced_on;
    logic ext_reset_disabled;
    logic data_memory_preserve;
    logic [7:0] clock_setup;
  } lfss_settings_t;

  // protection decisions
  typedef struct packed {
    logic program_allowed;
    logic verify_allowed;
    logic fuse_change_allowed;
    logic debug_allowed;
  } lfss_protect_t;
endpackage

// File: lfss_protect.sv
// lfss_protect: decodes lock bits and latched fuses into protection decisions
// assumes: purely combinational, output registered by the caller
module lfss_protect
  import lfss_pkg::*;
(
  input  wire logic [7:0]    lock_bit_byte,
  input  wire logic          debug_link_enable_fuse,
  input  wire logic          external_reset_disable_fuse,
  input  wire lfss_port_t    port,
  output lfss_protect_t      decision
);
  logic lock_bit_low;
  logic lock_bit_high;
  logic hv_only_ok;

  always_comb begin
    lock_bit_low  = lock_bit_byte[LFSS_LOCK_LOW_BIT];
    lock_bit_high = lock_bit_byte[LFSS_LOCK_HIGH_BIT];
    // reset pin given away: only high-voltage access may change anything
    hv_only_ok    = external_reset_disable_fuse || (port == LFSS_PORT_HV);
    // mode 1 leaves everything open, mode 2 blocks writes, mode 3 also reads
    decision.program_allowed     = lock_bit_low && hv_only_ok;
    decision.verify_allowed      = lock_bit_low || lock_bit_high;
    decision.fuse_change_allowed = lock_bit_low && hv_only_ok;
    // an enabled debug fuse keeps the link open despite locks
    decision.debug_allowed       = !debug_link_enable_fuse || lock_bit_low;
  end
endmodule

// File: lfss_sig_table.sv
// lfss_sig_table: read-only signature and calibration imprint table
// assumes: index valid whenever read; reserved entries return a fixed filler
module lfss_sig_table
  import lfss_pkg::*;
#(
  parameter logic [7:0] SIG_BYTE0   = 8'hA5,  // arbitrary identity value
  parameter logic [7:0] SIG_BYTE1   = 8'h5A,  // arbitrary identity value
  parameter logic [7:0] SIG_BYTE2   = 8'h3C,  // arbitrary identity value
  parameter logic [7:0] CALIBRATION = 8'h80
)(
  input  wire logic [7:0] index,
  output logic [7:0]      data
);
  always_comb begin
    case (index)
      LFSS_SIG_IDX0:    data = SIG_BYTE0;
      LFSS_SIG_IDX_CAL: data = CALIBRATION;
      LFSS_SIG_IDX1:    data = SIG_BYTE1;
      LFSS_SIG_IDX2:    data = SIG_BYTE2;
      default:          data = LFSS_SIG_RESERVED;
    endcase
  end
endmodule

// File: lfss_store.sv
// lfss_store: lock bits, three fuse bytes, working fuse latches and read-back
// assumes: rst is the power-up reset; programmer and firmware inputs are synchronous
module lfss_store
  import lfss_pkg::*;
#(
  parameter logic [7:0] SIG_BYTE0   = 8'hA5,  // arbitrary identity value
  parameter logic [7:0] SIG_BYTE1   = 8'h5A,  // arbitrary identity value
  parameter logic [7:0] SIG_BYTE2   = 8'h3C,  // arbitrary identity value
  parameter logic [7:0] CALIBRATION = 8'h80
)(
  input  wire logic           clk,
  input  wire logic           rst,
  input  wire lfss_port_t     prog_port,
  input  wire lfss_prog_req_t prog_req,
  input  wire logic           prog_read,
  input  wire logic [7:0]     prog_sig_index,
  input  wire logic           ctl_write,
  input  wire logic [7:0]     ctl_wdata,
  input  wire logic           fw_load,
  input  wire logic [15:0]    fw_pointer,
  input  wire logic           osc_cal_write,
  input  wire logic [7:0]     osc_cal_wdata,
  output logic [7:0]          prog_rdata,
  output logic                prog_refused,
  output logic [7:0]          prog_sig_data,
  output logic [7:0]          fw_rdata,
  output logic                fw_rvalid,
  output logic [7:0]          self_program_control_register,
  output logic [7:0]          oscillator_calibration_register,
  output lfss_settings_t      settings,
  output lfss_protect_t       protect,
  output logic                store_instruction_enable,
  output logic                data_erase_on_chip_erase
);
  typedef struct packed {
    logic [7:0]     lock;
    logic [7:0]     fuse_ext;
    logic [7:0]     fuse_high;
    logic [7:0]     fuse_low;
    logic [7:0]     work_ext;
    logic [7:0]     work_high;
    logic [7:0]     work_low;
    logic           in_prog;
    logic [7:0]     ctl;
    logic [1:0]     arm;
    logic [7:0]     osc_cal;
    logic           cal_loaded;
    logic [7:0]     prog_rdata;
    logic           prog_refused;
    logic [7:0]     prog_sig;
    logic [7:0]     fw_rdata;
    logic           fw_rvalid;
    lfss_settings_t settings;
    lfss_protect_t  protect;
    logic           spm_en;
    logic           erase_data;
  } lfss_state_t;

  lfss_state_t   state_reg;
  lfss_state_t   state_next;
  lfss_protect_t decision;
  logic [7:0]    sig_fw_data;
  logic [7:0]    sig_prog_data;
  logic [7:0]    sig_cal_data;
  logic [7:0]    lock_view;
  logic [7:0]    ext_view;
  logic [7:0]    fuse_wr;
  logic          entering;
  logic          fuse_ok;

  lfss_protect u_protect (
    .lock_bit_byte               (state_reg.lock),
    .debug_link_enable_fuse      (state_reg.work_high[LFSS_DEBUG_BIT]),
    .external_reset_disable_fuse (state_reg.work_high[LFSS_RST_DIS_BIT]),
    .port                        (prog_port),
    .decision                    (decision)
  );

  lfss_sig_table #(
    .SIG_BYTE0   (SIG_BYTE0),
    .SIG_BYTE1   (SIG_BYTE1),
    .SIG_BYTE2   (SIG_BYTE2),
    .CALIBRATION (CALIBRATION)
  ) u_sig_fw (
    .index (fw_pointer[7:0]),
    .data  (sig_fw_data)
  );

  lfss_sig_table #(
    .SIG_BYTE0   (SIG_BYTE0),
    .SIG_BYTE1   (SIG_BYTE1),
    .SIG_BYTE2   (SIG_BYTE2),
    .CALIBRATION (CALIBRATION)
  ) u_sig_prog (
    .index (prog_sig_index),
    .data  (sig_prog_data)
  );

  lfss_sig_table #(
    .SIG_BYTE0   (SIG_BYTE0),
    .SIG_BYTE1   (SIG_BYTE1),
    .SIG_BYTE2   (SIG_BYTE2),
    .CALIBRATION (CALIBRATION)
  ) u_sig_cal (
    .index (LFSS_SIG_IDX_CAL),
    .data  (sig_cal_data)
  );

  always_comb begin
    state_next = state_reg;
    lock_view  = state_reg.lock | LFSS_LOCK_UNUSED;
    ext_view   = state_reg.fuse_ext | LFSS_EXT_UNUSED;
    entering   = (prog_port != LFSS_PORT_NONE) && !state_reg.in_prog;
    fuse_ok    = decision.fuse_change_allowed;
    fuse_wr    = prog_req.data;
    state_next.prog_refused = 1'b0;
    state_next.fw_rvalid    = 1'b0;

    // working latches follow the stored fuses on entry to programming and
    // while outside it, so values written inside act only after exit, except the preserve fuse
    state_next.in_prog = (prog_port != LFSS_PORT_NONE);
    if (entering || prog_port == LFSS_PORT_NONE) begin
      state_next.work_ext  = state_reg.fuse_ext;
      state_next.work_high = state_reg.fuse_high;
      state_next.work_low  = state_reg.fuse_low;
    end

    if (prog_port != LFSS_PORT_NONE && prog_req.erase) begin
      // fuses untouched by erase; only the lock bits go back to 1
      state_next.lock = LFSS_LOCK_RESET;
    end else if (prog_port != LFSS_PORT_NONE && prog_req.write) begin
      case (prog_req.target)
        LFSS_TGT_LOCK: begin
          // lock bits can only be programmed toward 0
          state_next.lock = state_reg.lock & prog_req.data;
        end
        LFSS_TGT_EXT: begin
          if (fuse_ok) state_next.fuse_ext = prog_req.data;
          else state_next.prog_refused = 1'b1;
        end
        LFSS_TGT_HIGH: begin
          // serial port cannot touch its own enable fuse
          if (prog_port == LFSS_PORT_SERIAL) begin
            fuse_wr[LFSS_SERIAL_BIT] = state_reg.fuse_high[LFSS_SERIAL_BIT];
          end
          if (fuse_ok) state_next.fuse_high = fuse_wr;
          else state_next.prog_refused = 1'b1;
        end
        LFSS_TGT_LOW: begin
          if (fuse_ok) state_next.fuse_low = prog_req.data;
          else state_next.prog_refused = 1'b1;
        end
        default: state_next.prog_refused = 1'b1;
      endcase
    end

    // programmer read-back of locks and fuses; signature always readable
    if (prog_read) begin
      case (prog_req.target)
        LFSS_TGT_LOCK: state_next.prog_rdata = lock_view;
        LFSS_TGT_EXT:  state_next.prog_rdata = ext_view;
        LFSS_TGT_HIGH: state_next.prog_rdata = state_reg.fuse_high;
        LFSS_TGT_LOW:  state_next.prog_rdata = state_reg.fuse_low;
        default:       state_next.prog_rdata = LFSS_SIG_RESERVED;
      endcase
    end
    state_next.prog_sig = sig_prog_data;

    // firmware control register arms a read for three cycles
    if (ctl_write) begin
      state_next.ctl = ctl_wdata & LFSS_CTL_MASK;
      state_next.arm = ctl_wdata[LFSS_CTL_STORE_EN] ? LFSS_ARM_CYCLES : 2'h0;
    end else if (state_reg.arm != 2'h0) begin
      state_next.arm = state_reg.arm - 2'h1;
      if (state_reg.arm == 2'h1 || fw_load) state_next.ctl = 8'h00;
    end
    if (fw_load && state_reg.arm != 2'h0) begin
      // a control write in the same cycle re-arms and wins over the auto-clear
      if (!ctl_write) begin
        state_next.arm = 2'h0;
        state_next.ctl = 8'h00;
      end
      state_next.fw_rvalid = 1'b1;
      if (state_reg.ctl[LFSS_CTL_READ_SIG]) begin
        state_next.fw_rdata = sig_fw_data;
      end else if (state_reg.ctl[LFSS_CTL_READ_FUSE]) begin
        case (fw_pointer)
          LFSS_PTR_FUSE_LOW:  state_next.fw_rdata = state_reg.fuse_low;
          LFSS_PTR_LOCK:      state_next.fw_rdata = lock_view;
          LFSS_PTR_FUSE_EXT:  state_next.fw_rdata = ext_view;
          LFSS_PTR_FUSE_HIGH: state_next.fw_rdata = state_reg.fuse_high;
          default:            state_next.fw_rdata = LFSS_SIG_RESERVED;
        endcase
      end else begin
        state_next.fw_rvalid = 1'b0;
      end
    end

    // calibration copied once while coming out of reset
    if (!state_reg.cal_loaded) begin
      state_next.osc_cal    = sig_cal_data;
      state_next.cal_loaded = 1'b1;
    end else if (osc_cal_write) begin
      state_next.osc_cal = osc_cal_wdata;
    end

    state_next.settings.self_prog_enable     = !state_reg.work_ext[LFSS_SELF_PROG_BIT];
    state_next.settings.debug_link_enable    = !state_reg.work_high[LFSS_DEBUG_BIT]
                                               && decision.debug_allowed;
    state_next.settings.watchdog_forced_on   = !state_reg.work_high[LFSS_WDT_ON_BIT];
    state_next.settings.ext_reset_disabled   = !state_reg.work_high[LFSS_RST_DIS_BIT];
    // preserve acts from the stored fuse, not the working latch
    state_next.settings.data_memory_preserve = !state_reg.fuse_high[LFSS_PRESERVE_BIT];
    state_next.settings.clock_setup          = state_reg.work_low;
    state_next.protect    = decision;
    state_next.spm_en     = !state_reg.work_ext[LFSS_SELF_PROG_BIT];
    state_next.erase_data = state_reg.fuse_high[LFSS_PRESERVE_BIT];
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg            <= '0;
      state_reg.lock       <= LFSS_LOCK_RESET;
      state_reg.fuse_ext   <= LFSS_EXT_DEFAULT;
      state_reg.fuse_high  <= LFSS_HIGH_DEFAULT;
      state_reg.fuse_low   <= LFSS_LOW_DEFAULT;
      // power-up latch of the defaults into the working copies
      state_reg.work_ext   <= LFSS_EXT_DEFAULT;
      state_reg.work_high  <= LFSS_HIGH_DEFAULT;
      state_reg.work_low   <= LFSS_LOW_DEFAULT;
      state_reg.prog_rdata <= LFSS_SIG_RESERVED;
      state_reg.prog_sig   <= LFSS_SIG_RESERVED;
      state_reg.fw_rdata   <= LFSS_SIG_RESERVED;
    end else begin
      state_reg <= state_next;
    end
  end

  always_comb begin
    prog_rdata                      = state_reg.prog_rdata;
    prog_refused                    = state_reg.prog_refused;
    prog_sig_data                   = state_reg.prog_sig;
    fw_rdata                        = state_reg.fw_rdata;
    fw_rvalid                       = state_reg.fw_rvalid;
    self_program_control_register   = state_reg.ctl;
    oscillator_calibration_register = state_reg.osc_cal;
    settings                        = state_reg.settings;
    protect                         = state_reg.protect;
    store_instruction_enable        = state_reg.spm_en;
    data_erase_on_chip_erase        = state_reg.erase_data;
  end
endmodule

// File: lfss_store_asserts.sv
// lfss_store_asserts: port-level checks on lfss_store
// assumes: bound to lfss_store, rising clk, rst synchronous active high
module lfss_store_asserts
  import lfss_pkg::*;
#(
  parameter logic [7:0] SIG_BYTE0   = 8'hA5,  // arbitrary identity value
  parameter logic [7:0] SIG_BYTE1   = 8'h5A,  // arbitrary identity value
  parameter logic [7:0] SIG_BYTE2   = 8'h3C,  // arbitrary identity value
  parameter logic [7:0] CALIBRATION = 8'h80
)(
  input wire logic           clk,
  input wire logic           rst,
  input wire lfss_port_t     prog_port,
  input wire lfss_prog_req_t prog_req,
  input wire logic [7:0]     prog_sig_index,
  input wire logic           ctl_write,
  input wire logic [7:0]     ctl_wdata,
  input wire logic           fw_load,
  input wire logic           osc_cal_write,
  input wire logic [7:0]     osc_cal_wdata,
  input wire logic           prog_refused,
  input wire logic [7:0]     prog_sig_data,
  input wire logic           fw_rvalid,
  input wire logic [7:0]     oscillator_calibration_register,
  input wire lfss_settings_t settings,
  input wire logic           store_instruction_enable,
  input wire logic           data_erase_on_chip_erase
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic [7:0] sig_exp;
  always_comb begin
    case (prog_sig_index)
      LFSS_SIG_IDX0:    sig_exp = SIG_BYTE0;
      LFSS_SIG_IDX_CAL: sig_exp = CALIBRATION;
      LFSS_SIG_IDX1:    sig_exp = SIG_BYTE1;
      LFSS_SIG_IDX2:    sig_exp = SIG_BYTE2;
      default:          sig_exp = LFSS_SIG_RESERVED;
    endcase
  end
  a_sig_table: assert property (1'b1 |=> prog_sig_data == $past(sig_exp))
    else $error("signature table data wrong");
  a_refuse_cause: assert property (prog_refused |-> $past(prog_req.write) && $past(prog_port) != LFSS_PORT_NONE)
    else $error("refusal without a fuse write");
  a_rvalid_cause: assert property (fw_rvalid |-> $past(fw_load))
    else $error("firmware read valid without load");
  a_load_unarmed: assert property (fw_load && !$past(ctl_write) && !$past(ctl_write, 2)
    && !$past(ctl_write, 3) |=> !fw_rvalid)
    else $error("load outside arm window answered");
  a_load_armed: assert property (ctl_write && ctl_wdata == 8'h09 ##1 fw_load && !ctl_write |=> fw_rvalid)
    else $error("armed load not answered");
  a_cal_on_release: assert property ($fell(rst) && !osc_cal_write |=> oscillator_calibration_register == CALIBRATION)
    else $error("calibration not loaded at reset");
  a_cal_fw_write: assert property (osc_cal_write |=> oscillator_calibration_register == $past(osc_cal_wdata))
    else $error("calibration write lost");
  a_preserve_now: assert property (prog_port == LFSS_PORT_HV && prog_req.write
    && prog_req.target == LFSS_TGT_HIGH && !prog_req.data[LFSS_PRESERVE_BIT]
    |-> ##[1:2] (prog_refused || !data_erase_on_chip_erase))
    else $error("preserve fuse not immediate");
  a_latched_in_prog: assert property (prog_port != LFSS_PORT_NONE && $past(prog_port) != LFSS_PORT_NONE
    && $past(prog_port, 2) != LFSS_PORT_NONE |-> $stable({settings.self_prog_enable, settings.watchdog_forced_on,
    settings.ext_reset_disabled, settings.clock_setup}))
    else $error("settings changed inside programming mode");
  a_store_latch: assert property (!$past(rst) |-> store_instruction_enable == settings.self_prog_enable)
    else $error("store enable disagrees with latch");
  c_fw_read: cover property (fw_rvalid);
  c_refused: cover property (prog_refused);
  c_preserve: cover property (!data_erase_on_chip_erase);
endmodule

bind lfss_store lfss_store_asserts #(.SIG_BYTE0(SIG_BYTE0), .SIG_BYTE1(SIG_BYTE1), .SIG_BYTE2(SIG_BYTE2),
  .CALIBRATION(CALIBRATION)) u_asserts (.clk, .rst, .prog_port, .prog_req, .prog_sig_index, .ctl_write, .ctl_wdata,
  .fw_load, .osc_cal_write, .osc_cal_wdata, .prog_refused, .prog_sig_data, .fw_rvalid,
  .oscillator_calibration_register, .settings, .store_instruction_enable, .data_erase_on_chip_erase);

// File: lfss_prog_model.sv
// lfss_prog_model: behavioural external programmer on the store's programming port
// assumes: tasks called from the bench; drives on falling edge, answer read one cycle on
module lfss_prog_model
  import lfss_pkg::*;
(
  input  wire logic       clk,
  input  wire logic [7:0] prog_rdata,
  input  wire logic       prog_refused,
  output lfss_port_t      prog_port,
  output lfss_prog_req_t  prog_req,
  output logic            prog_read
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    prog_port = LFSS_PORT_NONE;
    prog_req  = 12'h000;
    prog_read = 1'b0;
  end
  task automatic enter(input lfss_port_t p);
    @(negedge clk);
    prog_port = p;
  endtask
  // released data shows the inverse so a stale byte can never pass for a fresh one
  task automatic op(input logic wr, input logic er, input logic rd, input lfss_target_t tgt,
                    input logic [7:0] d, output logic [7:0] rdata, output logic refused);
    @(negedge clk);
    prog_req  = '{write: wr, erase: er, target: tgt, data: d};
    prog_read = rd;
    @(negedge clk);
    rdata     = prog_rdata;
    refused   = prog_refused;
    prog_req  = '{write: 1'b0, erase: 1'b0, target: tgt, data: ~d};
    prog_read = 1'b0;
  endtask
endmodule

// File: lfss_store_tb.sv
// lfss_store_tb: self-checking bench for lfss_store
// assumes: lfss_prog_model on the programming port, firmware side driven here
module lfss_store_tb
  import lfss_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] DEF [4] = '{8'h62, 8'hFF, 8'hFF, 8'hDF};
  localparam logic [7:0] IDX [7] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h2A};
  logic clk, rst, ctl_write, fw_load, osc_cal_write, prog_read, prog_refused, fw_rvalid, rf;
  logic store_instruction_enable, data_erase_on_chip_erase;
  logic [7:0] prog_sig_index, ctl_wdata, osc_cal_wdata, prog_rdata, prog_sig_data, fw_rdata, rd;
  logic [7:0] self_program_control_register, oscillator_calibration_register;
  logic [15:0] fw_pointer;
  lfss_port_t prog_port;
  lfss_prog_req_t prog_req;
  lfss_settings_t settings;
  lfss_protect_t protect;
  int n_errors = 0;
  int num_checks = 0;
  int cycles = 0;
  lfss_store dut (.clk, .rst, .prog_port, .prog_req, .prog_read, .prog_sig_index, .ctl_write, .ctl_wdata,
    .fw_load, .fw_pointer, .osc_cal_write, .osc_cal_wdata, .prog_rdata, .prog_refused, .prog_sig_data,
    .fw_rdata, .fw_rvalid, .self_program_control_register, .oscillator_calibration_register, .settings,
    .protect, .store_instruction_enable, .data_erase_on_chip_erase);
  lfss_prog_model prog (.clk, .prog_rdata, .prog_refused, .prog_port, .prog_req, .prog_read);
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  function automatic logic [7:0] sig_exp(input logic [7:0] i);
    case (i)
      8'h00:   return 8'hA5;
      8'h01:   return 8'h80;
      8'h02:   return 8'h5A;
      8'h04:   return 8'h3C;
      default: return 8'hFF;
    endcase
  endfunction
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic pw(input lfss_target_t t, input logic [7:0] d, input logic exp_ref);
    prog.op(1'b1, 1'b0, 1'b0, t, d, rd, rf);
    chk({7'h00, rf}, {7'h00, exp_ref});
  endtask
  task automatic pr(input lfss_target_t t, input logic [7:0] exp);
    prog.op(1'b0, 1'b0, 1'b1, t, 8'h00, rd, rf);
    chk(rd, exp);
  endtask
  task automatic fw_read(input logic [7:0] ctl, input logic [15:0] ptr, input int gap,
                         input logic exp_v, input logic [7:0] exp);
    @(negedge clk);
    ctl_write = 1'b1;
    ctl_wdata = ctl;
    @(negedge clk);
    ctl_write = 1'b0;
    chk(self_program_control_register, ctl);
    repeat (gap) @(negedge clk);
    fw_load    = 1'b1;
    fw_pointer = ptr;
    @(negedge clk);
    fw_load = 1'b0;
    chk({7'h00, fw_rvalid}, {7'h00, exp_v});
    if (exp_v) chk(fw_rdata, exp);
    chk(self_program_control_register, 8'h00);
  endtask
  task automatic defaults_and_table();
    for (int i = 0; i < 4; i++) fw_read(8'h09, 16'(i), 0, 1'b1, DEF[i]);
    for (int i = 0; i < 7; i++) begin
      fw_read(8'h21, {8'h00, IDX[i]}, 0, 1'b1, sig_exp(IDX[i]));
      prog_sig_index = IDX[i];
      @(negedge clk);
      chk(prog_sig_data, sig_exp(IDX[i]));
    end
  endtask
  task automatic report_and_stop();
    $display("checks=%0d errors=%0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // ceiling well above the fewer than two hundred cycles the sequence needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      report_and_stop();
    end
  end
  initial begin
    rst = 1'b1;
    prog_sig_index = 8'h00;
    ctl_write = 1'b0;
    ctl_wdata = 8'h00;
    fw_load = 1'b0;
    fw_pointer = 16'h0000;
    osc_cal_write = 1'b0;
    osc_cal_wdata = 8'h00;
    repeat (10) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    chk(oscillator_calibration_register, 8'h80);
    chk({7'h00, data_erase_on_chip_erase}, 8'h01);
    chk({7'h00, store_instruction_enable}, 8'h00);
    chk(settings.clock_setup, 8'h62);
    defaults_and_table();
    fw_read(8'h09, 16'h0003, 2, 1'b1, 8'hDF);
    fw_read(8'h09, 16'h0001, 3, 1'b0, 8'h00);
    fw_read(8'h01, 16'h0001, 0, 1'b0, 8'h00);
    prog.enter(LFSS_PORT_SERIAL);
    pw(LFSS_TGT_HIGH, 8'hFF, 1'b0);
    pr(LFSS_TGT_HIGH, 8'hDF);
    chk({4'h0, protect}, 8'h0F);
    prog.enter(LFSS_PORT_HV);
    pw(LFSS_TGT_EXT, 8'hFE, 1'b0);
    pw(LFSS_TGT_HIGH, 8'hC7, 1'b0);
    repeat (2) @(negedge clk);
    chk({7'h00, data_erase_on_chip_erase}, 8'h00);
    chk({7'h00, settings.watchdog_forced_on}, 8'h00);
    chk({7'h00, store_instruction_enable}, 8'h00);
    prog.enter(LFSS_PORT_NONE);
    repeat (3) @(negedge clk);
    chk({7'h00, settings.watchdog_forced_on}, 8'h01);
    chk({7'h00, store_instruction_enable}, 8'h01);
    chk({7'h00, settings.data_memory_preserve}, 8'h01);
    prog.enter(LFSS_PORT_HV);
    pw(LFSS_TGT_HIGH, 8'h47, 1'b0);
    prog.enter(LFSS_PORT_NONE);
    prog.enter(LFSS_PORT_SERIAL);
    pw(LFSS_TGT_LOW, 8'h00, 1'b1);
    prog.enter(LFSS_PORT_HV);
    pw(LFSS_TGT_LOW, 8'h64, 1'b0);
    pr(LFSS_TGT_LOW, 8'h64);
    pw(LFSS_TGT_LOCK, 8'hFE, 1'b0);
    pr(LFSS_TGT_LOCK, 8'hFE);
    chk({4'h0, protect}, 8'h04);
    pw(LFSS_TGT_LOW, 8'h62, 1'b1);
    pw(LFSS_TGT_LOCK, 8'hFC, 1'b0);
    pw(LFSS_TGT_LOCK, 8'hFF, 1'b0);
    pr(LFSS_TGT_LOCK, 8'hFC);
    chk({4'h0, protect}, 8'h00);
    prog_sig_index = 8'h00;
    @(negedge clk);
    chk(prog_sig_data, 8'hA5);
    prog.op(1'b0, 1'b1, 1'b0, LFSS_TGT_LOCK, 8'h00, rd, rf);
    pr(LFSS_TGT_LOCK, 8'hFF);
    pr(LFSS_TGT_HIGH, 8'h47);
    pr(LFSS_TGT_LOW, 8'h64);
    prog.enter(LFSS_PORT_NONE);
    @(negedge clk);
    osc_cal_write = 1'b1;
    osc_cal_wdata = 8'h33;
    @(negedge clk);
    osc_cal_write = 1'b0;
    chk(oscillator_calibration_register, 8'h33);
    chk({7'h00, settings.ext_reset_disabled}, 8'h01);
    chk({7'h00, settings.self_prog_enable}, 8'h01);
    chk(settings.clock_setup, 8'h64);
    prog.enter(LFSS_PORT_HV);
    pw(LFSS_TGT_HIGH, 8'h17, 1'b0);
    prog.enter(LFSS_PORT_NONE);
    prog.enter(LFSS_PORT_HV);
    pw(LFSS_TGT_LOCK, 8'hFC, 1'b0);
    @(negedge clk);
    chk({4'h0, protect}, 8'h01);
    chk({7'h00, settings.debug_link_enable}, 8'h01);
    prog.enter(LFSS_PORT_NONE);
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    chk(oscillator_calibration_register, 8'h80);
    defaults_and_table();
    report_and_stop();
  end
endmodule
